// [common/tpbio_pkg.sv]
/*
 * Shared constants and types for the timer pin-B function decoder:
 * register offsets, field positions, reset values and pin/event carriers.
 * Assumes a 32-bit AXI4-Lite register bus with byte addresses.
 */
package tpbio_pkg;
	localparam int CNT_W = 16;
	localparam int ADDR_W = 8;
	localparam int LANES = CNT_W / 8;
	localparam logic [7:0] OFF_IO1 = 8'h00;
	localparam logic [7:0] OFF_IO2 = 8'h04;
	localparam logic [7:0] OFF_GRB1 = 8'h08;
	localparam logic [7:0] OFF_GRB2 = 8'h0c;
	localparam logic [7:0] OFF_CC1 = 8'h10;
	localparam logic [7:0] OFF_MODE0 = 8'h14;
	localparam logic [7:0] OFF_IOD0 = 8'h18;
	localparam logic [7:0] OFF_STAT = 8'h1c;
	localparam logic [7:0] OFF_CLR = 8'h20;
	localparam logic [7:0] OFF_EN = 8'h24;
	localparam int FN_LSB = 4;
	localparam int FB_CAP = 3;
	localparam int FB_INIT = 2;
	localparam int FB_SRC = 2;
	localparam int PSC_W = 3;
	localparam logic [2:0] PSC_UNDIV = 3'h0;
	localparam int BFB_BIT = 5;
	localparam int NEVT = 5;
	localparam logic [7:0] IO_RST = 8'h00;
	localparam logic [CNT_W-1:0] GRB_RST = 16'h0000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {
		ACT_OFF = 2'h0,
		ACT_LOW = 2'h1,
		ACT_HIGH = 2'h2,
		ACT_TOG = 2'h3
	} tpbio_act_e;
	typedef struct packed {
		logic o;
		logic oe;
	} tpbio_pin_s;
	typedef struct packed {
		logic d0;
		logic cap2;
		logic cmp2;
		logic cap1;
		logic cmp1;
	} tpbio_evt_s;
endpackage

// [rtl/tpbio_chan.sv]
/*
 * One timer channel's register B with its pin: output compare or
 * input capture as the 4-bit pin function selects.
 * Assumes counter and ch0c_evt come from logic on aclk; pin_raw is async.
 */
`timescale 1ns/1ps
module tpbio_chan #(
	parameter int CNT_W = tpbio_pkg::CNT_W,
	parameter bit CH0_SRC = 1'b0
) (
	input wire logic aclk, // clock
	input wire logic aresetn, // sync reset, low
	input wire logic [3:0] func, // pin b function field
	input wire logic init_ld, // field was just written
	input wire logic [CNT_W-1:0] counter, // channel counter
	input wire logic pin_raw, // pin level, async
	input wire logic ch0c_evt, // ch0 reg c match/capture
	input wire logic [CNT_W/8-1:0] reg_we, // byte lane writes
	input wire logic [CNT_W-1:0] reg_wdata, // write data
	output logic [CNT_W-1:0] reg_q, // general register b
	output tpbio_pkg::tpbio_pin_s pin_q, // pin drive
	output logic match, // compare match pulse
	output logic capture // capture pulse
);
	import tpbio_pkg::*;

	logic [2:0] sync_q;
	logic eq_q;
	logic [CNT_W-1:0] reg_d;
	tpbio_pin_s pin_d;
	logic cmp_mode;
	logic ch0_sel;
	logic rise;
	logic fall;
	logic edge_hit;
	logic init_lvl;
	tpbio_act_e act;

	assign cmp_mode = !func[FB_CAP];
	assign act = tpbio_act_e'(func[1:0]);
	assign init_lvl = func[FB_INIT];
	// ch2 has no alternate source, bit 6 falls away
	assign ch0_sel = CH0_SRC && func[FB_SRC];
	assign rise = sync_q[1] && !sync_q[2];
	assign fall = !sync_q[1] && sync_q[2];

	always_comb begin
		edge_hit = 1'b0;
		if (func[1]) begin
			edge_hit = rise || fall;
		end else if (func[0]) begin
			edge_hit = fall;
		end else begin
			edge_hit = rise;
		end
	end

	// one pulse per arrival at equality, a stalled counter does not re-fire
	assign match = cmp_mode && (counter == reg_q) && !eq_q;
	assign capture = !cmp_mode && (ch0_sel ? ch0c_evt : edge_hit);

	always_comb begin
		reg_d = reg_q;
		for (int i = 0; i < CNT_W / 8; i++) begin
			if (reg_we[i]) begin
				reg_d[i*8 +: 8] = reg_wdata[i*8 +: 8];
			end
		end
		// capture beats a bus write in the same cycle
		if (capture) begin
			reg_d = counter;
		end
		pin_d.o = pin_q.o;
		pin_d.oe = cmp_mode && (act != ACT_OFF);
		if (init_ld) begin
			pin_d.o = init_lvl;
		end else if (match) begin
			unique case (act)
				ACT_OFF: pin_d.o = pin_q.o;
				ACT_LOW: pin_d.o = 1'b0;
				ACT_HIGH: pin_d.o = 1'b1;
				ACT_TOG: pin_d.o = !pin_q.o;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync_q <= 3'h0;
			eq_q <= 1'b0;
			reg_q <= GRB_RST;
			pin_q <= '0;
		end else begin
			sync_q <= {sync_q[1:0], pin_raw};
			eq_q <= cmp_mode && (counter == reg_q);
			reg_q <= reg_d;
			pin_q <= pin_d;
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	chk_init_level: assert property (init_ld |=> pin_q.o == $past(init_lvl))
		else $error("pin level not loaded from init bit");
	chk_drive_low: assert property (match && !init_ld && act == ACT_LOW |=> !pin_q.o)
		else $error("pin not low after match");
	chk_drive_high: assert property (match && !init_ld && act == ACT_HIGH |=> pin_q.o)
		else $error("pin not high after match");
	chk_toggle_pin: assert property (match && !init_ld && act == ACT_TOG |=> $changed(pin_q.o))
		else $error("pin did not toggle on match");
	chk_rise_latch: assert property (func == 4'h8 && !ch0_sel && $rose(sync_q[1])
		|=> reg_q == $past(counter))
		else $error("rising edge not captured");
	chk_fall_latch: assert property (func == 4'h9 && !ch0_sel && $fell(sync_q[1])
		|-> capture)
		else $error("falling edge not captured");
	chk_both_edges: assert property (func[3] && func[1] && !ch0_sel
		&& $changed(sync_q[1]) |-> capture)
		else $error("edge missed in both-edge mode");
	chk_ch0_source: assert property (CH0_SRC && func[3] && func[2] && ch0c_evt
		|=> reg_q == $past(counter))
		else $error("ch0 event not captured");
	chk_own_pin_only: assert property (!CH0_SRC && func[3] && !$changed(sync_q[1])
		|-> !capture)
		else $error("capture without own pin edge");
	chk_match_time: assert property (cmp_mode && counter == reg_q
		&& !($past(cmp_mode) && $past(counter) == $past(reg_q)) |-> match)
		else $error("compare match missed");
	cov_toggle: cover property (match && act == ACT_TOG ##1 pin_q.oe);
	cov_capture: cover property (capture && !ch0_sel);
endmodule

// [rtl/tpbio_top.sv]
/*
 * Pin-B function decoder for timer channels 1 and 2 with an AXI4-Lite
 * register slave, sticky event status and one level interrupt; also gates
 * the channel 0 register D events.
 * Assumes counters and ch0 event strobes come from logic on aclk.
 */
// The AXI4-Lite interface to the registers and the address map were left to the implementer.
// Contract
// - bit 7 low: reg b compares, bit 6 sets the first level, 00 pin off, 01 low on match.
// - compare code 10 drives the pin high on each match, from the initial level.
// - compare code 11 toggles the pin on each match, from the initial level.
// - code 1000 captures the counter on a rising edge of the own pin.
// - code 1001 captures the counter on a falling edge of the own pin.
// - code 101x captures on both pin edges, bit 4 ignored.
// - on channel 1 code 11xx captures on each ch0 reg c match or capture.
// - on channel 2 bit 6 is ignored in capture mode, the source is always the own pin.
// - capture on ch1 counting is suppressed when ch1 prescale select is 000.
// - with ch0 buffer mode set, ch0 reg d makes neither capture nor compare.
`timescale 1ns/1ps
module tpbio_top #(
	parameter int CNT_W = tpbio_pkg::CNT_W
) (
	input wire logic aclk, // clock, 100 MHz
	input wire logic aresetn, // sync reset, low
	input wire logic [tpbio_pkg::ADDR_W-1:0] awaddr, // write address
	input wire logic awvalid, // write address valid
	output logic awready, // write address ready
	input wire logic [31:0] wdata, // write data
	input wire logic [3:0] wstrb, // byte strobes
	input wire logic wvalid, // write data valid
	output logic wready, // write data ready
	output logic [1:0] bresp, // write response
	output logic bvalid, // response valid
	input wire logic bready, // response ready
	input wire logic [tpbio_pkg::ADDR_W-1:0] araddr, // read address
	input wire logic arvalid, // read address valid
	output logic arready, // read address ready
	output logic [31:0] rdata, // read data
	output logic [1:0] rresp, // read response
	output logic rvalid, // read data valid
	input wire logic rready, // read data ready
	input wire logic [CNT_W-1:0] ch1_counter, // channel 1 counter
	input wire logic [CNT_W-1:0] ch2_counter, // channel 2 counter
	input wire logic ch0c_event, // ch0 reg c match/capture
	input wire logic ch1_count_evt, // ch1 counter stepped
	input wire logic ch0d_match_raw, // ch0 reg d match, ungated
	input wire logic ch0d_pin_cap_raw, // ch0 reg d pin edge, ungated
	input wire logic ch1_pin_b_level, // channel 1 pin level
	input wire logic ch2_pin_b_level, // channel 2 pin level
	output tpbio_pkg::tpbio_pin_s ch1_pin_b, // channel 1 pin drive
	output tpbio_pkg::tpbio_pin_s ch2_pin_b, // channel 2 pin drive
	output logic ch0d_capture, // ch0 reg d capture strobe
	output logic ch0d_compare, // ch0 reg d compare strobe
	output logic irq // interrupt, level
);
	import tpbio_pkg::*;

	logic awr_q, awr_d;
	logic wr_q, wr_d;
	logic awh_q, awh_d;
	logic wh_q, wh_d;
	logic [ADDR_W-1:0] awa_q, awa_d;
	logic [31:0] wd_q, wd_d;
	logic [3:0] ws_q, ws_d;
	logic bv_q, bv_d;
	logic [1:0] br_q, br_d;
	logic arr_q, arr_d;
	logic rv_q, rv_d;
	logic [31:0] rd_q, rd_d;
	logic [1:0] rr_q, rr_d;

	logic [7:0] io1_q, io1_d;
	logic [7:0] io2_q, io2_d;
	logic [PSC_W-1:0] psc_q, psc_d;
	logic bfb_q, bfb_d;
	logic [3:0] iod_q, iod_d;
	logic [NEVT-1:0] stat_q, stat_d;
	logic [NEVT-1:0] en_q, en_d;
	logic irq_q, irq_d;
	logic [1:0] ld_q, ld_d;
	logic d0cap_q, d0cap_d;
	logic d0cmp_q, d0cmp_d;

	logic [NEVT-1:0] clr;
	logic [LANES-1:0] grb1_we;
	logic [LANES-1:0] grb2_we;
	logic [CNT_W-1:0] grb1;
	logic [CNT_W-1:0] grb2;
	logic m1, m2, c1, c2;
	logic d0_ch1src;
	logic d0_cap_raw;
	tpbio_evt_s ev;

	assign awready = awr_q;
	assign wready = wr_q;
	assign bvalid = bv_q;
	assign bresp = br_q;
	assign arready = arr_q;
	assign rvalid = rv_q;
	assign rdata = rd_q;
	assign rresp = rr_q;
	assign irq = irq_q;
	assign ch0d_capture = d0cap_q;
	assign ch0d_compare = d0cmp_q;

	tpbio_chan #(
		.CNT_W(CNT_W),
		.CH0_SRC(1'b1)
	) u_ch1 (
		.aclk(aclk),
		.aresetn(aresetn),
		.func(io1_q[FN_LSB +: 4]),
		.init_ld(ld_q[0]),
		.counter(ch1_counter),
		.pin_raw(ch1_pin_b_level),
		.ch0c_evt(ch0c_event),
		.reg_we(grb1_we),
		.reg_wdata(wd_q[CNT_W-1:0]),
		.reg_q(grb1),
		.pin_q(ch1_pin_b),
		.match(m1),
		.capture(c1)
	);

	tpbio_chan #(
		.CNT_W(CNT_W),
		.CH0_SRC(1'b0)
	) u_ch2 (
		.aclk(aclk),
		.aresetn(aresetn),
		.func(io2_q[FN_LSB +: 4]),
		.init_ld(ld_q[1]),
		.counter(ch2_counter),
		.pin_raw(ch2_pin_b_level),
		.ch0c_evt(1'b0),
		.reg_we(grb2_we),
		.reg_wdata(wd_q[CNT_W-1:0]),
		.reg_q(grb2),
		.pin_q(ch2_pin_b),
		.match(m2),
		.capture(c2)
	);

	// ch0 reg d gating
	assign d0_ch1src = iod_q[FB_CAP] && iod_q[FB_SRC];
	// undivided clock on ch1 gives no usable count event
	assign d0_cap_raw = d0_ch1src ? (ch1_count_evt && psc_q != PSC_UNDIV)
		: ch0d_pin_cap_raw;

	always_comb begin
		d0cap_d = !bfb_q && iod_q[FB_CAP] && d0_cap_raw;
		d0cmp_d = !bfb_q && !iod_q[FB_CAP] && ch0d_match_raw;
		ev.cmp1 = m1;
		ev.cap1 = c1;
		ev.cmp2 = m2;
		ev.cap2 = c2;
		ev.d0 = d0cap_d || d0cmp_d;
	end

	// register write side
	always_comb begin
		awh_d = awh_q;
		wh_d = wh_q;
		awa_d = awa_q;
		wd_d = wd_q;
		ws_d = ws_q;
		bv_d = bv_q;
		br_d = br_q;
		io1_d = io1_q;
		io2_d = io2_q;
		psc_d = psc_q;
		bfb_d = bfb_q;
		iod_d = iod_q;
		en_d = en_q;
		clr = '0;
		grb1_we = '0;
		grb2_we = '0;
		ld_d = 2'h0;
		if (awvalid && awr_q) begin
			awh_d = 1'b1;
			awa_d = awaddr;
		end
		if (wvalid && wr_q) begin
			wh_d = 1'b1;
			wd_d = wdata;
			ws_d = wstrb;
		end
		if (awh_q && wh_q && !bv_q) begin
			awh_d = 1'b0;
			wh_d = 1'b0;
			bv_d = 1'b1;
			br_d = RESP_OKAY;
			unique case ({awa_q[ADDR_W-1:2], 2'h0})
				OFF_IO1: begin
					if (ws_q[0]) begin
						io1_d = wd_q[7:0];
						ld_d[0] = 1'b1;
					end
				end
				OFF_IO2: begin
					if (ws_q[0]) begin
						io2_d = wd_q[7:0];
						ld_d[1] = 1'b1;
					end
				end
				OFF_GRB1: grb1_we = ws_q[LANES-1:0];
				OFF_GRB2: grb2_we = ws_q[LANES-1:0];
				OFF_CC1: begin
					if (ws_q[0]) begin
						psc_d = wd_q[PSC_W-1:0];
					end
				end
				OFF_MODE0: begin
					if (ws_q[0]) begin
						bfb_d = wd_q[BFB_BIT];
					end
				end
				OFF_IOD0: begin
					if (ws_q[0]) begin
						iod_d = wd_q[FN_LSB +: 4];
					end
				end
				OFF_CLR: begin
					if (ws_q[0]) begin
						clr = wd_q[NEVT-1:0];
					end
				end
				OFF_EN: begin
					if (ws_q[0]) begin
						en_d = wd_q[NEVT-1:0];
					end
				end
				OFF_STAT: br_d = RESP_OKAY;
				default: br_d = RESP_SLVERR;
			endcase
		end
		if (bv_q && bready) begin
			bv_d = 1'b0;
		end
		awr_d = !awh_d;
		wr_d = !wh_d;
	end

	// register read side
	always_comb begin
		rv_d = rv_q;
		rd_d = rd_q;
		rr_d = rr_q;
		if (arvalid && arr_q) begin
			rv_d = 1'b1;
			rr_d = RESP_OKAY;
			rd_d = 32'h0;
			unique case ({araddr[ADDR_W-1:2], 2'h0})
				OFF_IO1: rd_d[7:0] = io1_q;
				OFF_IO2: rd_d[7:0] = io2_q;
				OFF_GRB1: rd_d[CNT_W-1:0] = grb1;
				OFF_GRB2: rd_d[CNT_W-1:0] = grb2;
				OFF_CC1: rd_d[PSC_W-1:0] = psc_q;
				OFF_MODE0: rd_d[BFB_BIT] = bfb_q;
				OFF_IOD0: rd_d[FN_LSB +: 4] = iod_q;
				OFF_STAT: rd_d[NEVT-1:0] = stat_q;
				OFF_CLR: rd_d = 32'h0;
				OFF_EN: rd_d[NEVT-1:0] = en_q;
				default: rr_d = RESP_SLVERR;
			endcase
		end
		if (rv_q && rready) begin
			rv_d = 1'b0;
		end
		arr_d = !rv_d;
	end

	// sticky status: an event in the clearing cycle survives
	always_comb begin
		stat_d = (stat_q & ~clr) | ev;
		irq_d = |(stat_d & en_d);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awr_q <= 1'b0;
			wr_q <= 1'b0;
			awh_q <= 1'b0;
			wh_q <= 1'b0;
			awa_q <= '0;
			wd_q <= 32'h0;
			ws_q <= 4'h0;
			bv_q <= 1'b0;
			br_q <= RESP_OKAY;
			arr_q <= 1'b0;
			rv_q <= 1'b0;
			rd_q <= 32'h0;
			rr_q <= RESP_OKAY;
			io1_q <= IO_RST;
			io2_q <= IO_RST;
			psc_q <= PSC_UNDIV;
			bfb_q <= 1'b0;
			iod_q <= 4'h0;
			stat_q <= '0;
			en_q <= '0;
			irq_q <= 1'b0;
			ld_q <= 2'h0;
			d0cap_q <= 1'b0;
			d0cmp_q <= 1'b0;
		end else begin
			awr_q <= awr_d;
			wr_q <= wr_d;
			awh_q <= awh_d;
			wh_q <= wh_d;
			awa_q <= awa_d;
			wd_q <= wd_d;
			ws_q <= ws_d;
			bv_q <= bv_d;
			br_q <= br_d;
			arr_q <= arr_d;
			rv_q <= rv_d;
			rd_q <= rd_d;
			rr_q <= rr_d;
			io1_q <= io1_d;
			io2_q <= io2_d;
			psc_q <= psc_d;
			bfb_q <= bfb_d;
			iod_q <= iod_d;
			stat_q <= stat_d;
			en_q <= en_d;
			irq_q <= irq_d;
			ld_q <= ld_d;
			d0cap_q <= d0cap_d;
			d0cmp_q <= d0cmp_d;
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	chk_prescale_block: assert property (d0_ch1src && psc_q == PSC_UNDIV |=> !ch0d_capture)
		else $error("capture from undivided ch1 count");
	chk_ch1_count_cap: assert property (d0_ch1src && !bfb_q && psc_q != PSC_UNDIV
		&& ch1_count_evt |=> ch0d_capture)
		else $error("ch1 count capture missed");
	chk_buffer_block: assert property (bfb_q |=> !ch0d_capture && !ch0d_compare)
		else $error("reg d event while buffering");
	chk_set_wins: assert property (m1 |=> stat_q[0] ##0 irq == |(stat_q & en_q))
		else $error("compare event lost or irq wrong");
	chk_cap_status: assert property (c2 |=> stat_q[3])
		else $error("ch2 capture not flagged");
	cov_irq: cover property (!irq ##1 irq);
	cov_ch0_src: cover property (c1 && io1_q[FN_LSB + FB_SRC]);
	cov_buffer: cover property (bfb_q && ch0d_match_raw);
endmodule

// [tb/tpbio_pins.sv]
/*
 * Far-side model of the two pin-B pads: an outside source drives each pad
 * unless the block enables its own driver.
 * Assumes outside levels come from the bench; they reach the pad late.
 */
`timescale 1ns/1ps
module tpbio_pins #(
	parameter int DLY = 3
) (
	input tpbio_pkg::tpbio_pin_s drv1, // block drive, ch1
	input tpbio_pkg::tpbio_pin_s drv2, // block drive, ch2
	input logic ext1, // outside level, ch1
	input logic ext2, // outside level, ch2
	output logic lvl1, // pad level, ch1
	output logic lvl2 // pad level, ch2
);
	import tpbio_pkg::*;
	logic e1 = 1'b0;
	logic e2 = 1'b0;
	// late arrival keeps pad edges away from the clock edge
	always @(ext1) e1 <= #DLY ext1;
	always @(ext2) e2 <= #DLY ext2;
	assign lvl1 = drv1.oe ? drv1.o : e1;
	assign lvl2 = drv2.oe ? drv2.o : e2;
endmodule

// [tb/testbench.sv]
/*
 * Self-checking bench for the pin-B function decoder: register bus,
 * compare and capture codes of both channels, ch0 reg d gating, interrupt.
 * Assumes the pad model sits between the block and the bench's pin levels.
 */
`timescale 1ns/1ps
module testbench;
	import tpbio_pkg::*;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'h0;
	logic awready, wready, bvalid, arready, rvalid, irq, d_cap, d_cmp, p1, p2;
	logic [1:0] bresp, rresp, rsp;
	logic [31:0] rdata, rdv;
	logic [15:0] c1 = 16'h0, c2 = 16'h0;
	logic c0e = 1'b0, cnt_e = 1'b0, dm = 1'b0, dp = 1'b0, x1 = 1'b0, x2 = 1'b0, en;
	tpbio_pin_s b1, b2;
	int n_fail = 0, compares = 0, n_dcap = 0, n_dcmp = 0;

	always #5 aclk = ~aclk;
	always @(posedge aclk) begin
		n_dcap += int'(d_cap === 1'b1);
		n_dcmp += int'(d_cmp === 1'b1);
	end

	tpbio_top u_tpbio_top (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.ch1_counter(c1), .ch2_counter(c2), .ch0c_event(c0e), .ch1_count_evt(cnt_e),
		.ch0d_match_raw(dm), .ch0d_pin_cap_raw(dp), .ch1_pin_b_level(p1),
		.ch2_pin_b_level(p2), .ch1_pin_b(b1), .ch2_pin_b(b2), .ch0d_capture(d_cap),
		.ch0d_compare(d_cmp), .irq(irq));
	tpbio_pins u_tpbio_pins (.drv1(b1), .drv2(b2), .ext1(x1), .ext2(x2),
		.lvl1(p1), .lvl2(p2));

	task automatic end_of_test;
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		rsp = bresp;
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rdv = rdata;
		rsp = rresp;
		rready <= 1'b0;
	endtask
	task automatic cnt(input int ch, input logic [15:0] v);
		if (ch == 1) c1 <= v;
		else c2 <= v;
	endtask
	task automatic ext(input int ch, input logic l);
		if (ch == 1) x1 <= l;
		else x2 <= l;
	endtask
	function automatic tpbio_pin_s pin(input int ch);
		return ch == 1 ? b1 : b2;
	endfunction
	function automatic logic xo(input logic [3:0] f);
		return f[1:0] == 2'h1 ? 1'b0 : f[1:0] == 2'h2 ? 1'b1 : f[2] ^ (f[1:0] == 2'h3);
	endfunction
	function automatic logic hit(input logic [3:0] e, input logic r);
		return !e[2] && (e[1] || (e[0] ^ r));
	endfunction

	task automatic cmp_run(input int ch, input logic [3:0] f);
		logic [7:0] io;
		logic [15:0] v;
		logic [1:0] m;
		io = ch == 1 ? OFF_IO1 : OFF_IO2;
		v = 16'($urandom_range(1, 65535));
		// level of a disabled pin is not part of the contract
		m = {f[1:0] != 2'h0, 1'b1};
		cnt(ch, 16'h0);
		wr(io + 8'h08, {16'h0, v});
		wr(io, {24'h0, f, 4'h0});
		cyc(2);
		chk("pin init", 32'(pin(ch) & m), 32'({f[2], f[1:0] != 2'h0} & m));
		cnt(ch, v);
		cyc(3);
		chk("pin match", 32'(pin(ch) & m), 32'({xo(f), f[1:0] != 2'h0} & m));
		if (f[1:0] == 2'h3) begin
			cnt(ch, 16'h0);
			cyc(2);
			cnt(ch, v);
			cyc(3);
			chk("pin toggle", 32'(pin(ch)), {30'h0, f[2], 1'b1});
		end
		rd(OFF_STAT);
		chk("cmp status", 32'(rdv[2*ch-2]), 32'h1);
		chk("irq", 32'(irq), 32'(en));
		wr(OFF_CLR, 32'h1f);
		cyc(1);
		chk("irq clear", 32'(irq), 32'h0);
		cnt(ch, 16'h0);
	endtask

	task automatic cap_run(input int ch, input logic [3:0] f);
		logic [7:0] io;
		logic [15:0] v, w;
		logic [3:0] e;
		io = ch == 1 ? OFF_IO1 : OFF_IO2;
		e = ch == 1 ? f : {f[3], 1'b0, f[1:0]};
		v = 16'($urandom_range(1, 65535));
		w = 16'($urandom_range(1, 65535));
		ext(ch, 1'b0);
		wr(io, {24'h0, f, 4'h0});
		// let a pad settling edge land before the register is cleared
		cyc(5);
		wr(io + 8'h08, 32'h0);
		cnt(ch, v);
		ext(ch, 1'b1);
		cyc(8);
		rd(io + 8'h08);
		chk("cap rise", rdv, hit(e, 1'b1) ? 32'(v) : 32'h0);
		cnt(ch, w);
		ext(ch, 1'b0);
		cyc(8);
		rd(io + 8'h08);
		chk("cap fall", rdv, hit(e, 1'b0) ? 32'(w) : hit(e, 1'b1) ? 32'(v) : 32'h0);
		if (e[2]) begin
			c0e <= 1'b1;
			cyc(1);
			c0e <= 1'b0;
			cyc(4);
			rd(io + 8'h08);
			chk("cap ch0c", rdv, 32'(w));
		end
		rd(OFF_STAT);
		chk("cap status", 32'(rdv[2*ch-1]), 32'h1);
		wr(OFF_CLR, 32'h1f);
	endtask

	task automatic dz(input int k, input int ecap, input int ecmp);
		int a;
		int b;
		a = n_dcap;
		b = n_dcmp;
		if (k == 0) cnt_e <= 1'b1;
		else if (k == 1) dm <= 1'b1;
		else dp <= 1'b1;
		cyc(1);
		cnt_e <= 1'b0;
		dm <= 1'b0;
		dp <= 1'b0;
		cyc(4);
		chk("d capture", 32'(n_dcap - a), 32'(ecap));
		chk("d compare", 32'(n_dcmp - b), 32'(ecmp));
	endtask

	initial begin
		void'($urandom(32'h5959));
		cyc(16);
		aresetn <= 1'b1;
		cyc(2);
		chk("pin reset", 32'(b1), 32'h0);
		rd(OFF_IO1);
		chk("io reset", rdv, 32'h0);
		rd(8'h28);
		chk("unmapped", 32'(rsp), 32'(RESP_SLVERR));
		wr(8'h28, 32'h1);
		chk("unmapped wr", 32'(rsp), 32'(RESP_SLVERR));
		wr(OFF_STAT, 32'h1f);
		chk("status wr", 32'(rsp), 32'(RESP_OKAY));
		for (int ch = 1; ch < 3; ch++) begin
			en = ch == 1;
			wr(OFF_EN, en ? 32'h1f : 32'h0);
			for (int f = 0; f < 8; f++) cmp_run(ch, 4'(f));
			for (int f = 8; f < 16; f++) cap_run(ch, 4'(f));
		end
		wr(OFF_IOD0, 32'hc0);
		wr(OFF_CC1, 32'h0);
		dz(0, 0, 0);
		wr(OFF_CC1, 32'h1);
		dz(0, 1, 0);
		wr(OFF_IOD0, 32'h10);
		dz(1, 0, 1);
		wr(OFF_MODE0, 32'h20);
		dz(1, 0, 0);
		wr(OFF_IOD0, 32'h80);
		dz(2, 0, 0);
		wr(OFF_MODE0, 32'h0);
		dz(2, 1, 0);
		end_of_test;
	end

	initial begin
		// about seventeen times the expected run
		#200000;
		n_fail++;
		end_of_test;
	end
endmodule
